/* File: src/pwsc_pkg.sv */
package pwsc_pkg;

   // Register bus geometry.
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 16;

   // Register offsets.
   localparam logic [7:0]  OFS_LOW_POWER   = 8'h05;
   localparam logic [7:0]  OFS_CONFIG      = 8'h06;
   localparam logic [7:0]  OFS_HIB_SUPPLY  = 8'h07;
   localparam logic [7:0]  OFS_STATUS      = 8'h08;

   // Field positions.
   localparam int          BIT_LP_REQ      = 15;
   localparam int          BIT_ON_BUTTON_POLARITY      = 0;
   localparam int          BIT_WAKE_POL    = 1;
   localparam int          BIT_PWRON_POL   = 2;
   localparam int          BIT_HIB_POL     = 3;
   localparam int          BIT_SEQ_GO      = 4;
   localparam int          BIT_FIRST_LINEAR_REGULATOR_KEEP   = 5;

   // Reset values.
   localparam logic [15:0] RST_LOW_POWER   = 16'h0000;
   localparam logic [15:0] RST_CONFIG      = 16'h000f;
   localparam logic [15:0] RST_HIB_SUPPLY  = 16'h0000;

   // Supply counts.
   localparam int          N_CONV          = 6;
   localparam int          N_LDO           = 4;

   // Start-up input debounce time.
   localparam int          CLK_HZ          = 20_000_000;
   localparam int          DEBOUNCE_MS     = 40;
   localparam int          DEBOUNCE_CYC    = DEBOUNCE_MS * (CLK_HZ / 1000) + 1;
   localparam int          DEB_W           = 20;

   // Configuration modes, taken from the mode strap.
   localparam logic [1:0]  MODE_DEVELOP    = 2'h0;

   typedef enum logic [5:0] {
      ST_ZERO   = 6'h01,
      ST_BACKUP = 6'h02,
      ST_OFF    = 6'h04,
      ST_PREACT = 6'h08,
      ST_ACTIVE = 6'h10,
      ST_HIB    = 6'h20
   } pwsc_state_e;

   typedef struct packed {
      logic [N_CONV-1:0] conv;
      logic [N_LDO-1:0]  ldo;
   } pwsc_supply_s;

endpackage : pwsc_pkg

/* File: src/pwsc_top.sv */
`timescale 1ns/10ps

// Operation
// - ACTIVE only after fault-free valid start-up.
// - ACTIVE reached via PRE-ACTIVE after sequence.
// - Development mode holds PRE-ACTIVE until triggered.
// - Request bit or hibernate GPIO enters HIBERNATE.
// - Level release, edge, or wake exits HIBERNATE.
// - Fault in HIBERNATE forces OFF.
// - Low-power request is bit 15, reset 0.
// - HIBERNATE blocks fast charge, allows trickle.
// - OFF disables supplies, first regulator optional.
// - Entering OFF restores registers, trickle on.
// - Shutdown or low source moves ACTIVE to OFF.
// - Source above lockout moves BACKUP to OFF.
// - Main below lockout, backup ok: BACKUP.
// - BACKUP runs only oscillator and clock.
// - No source, backup below POR: ZERO.
// - Start-up event leaves OFF or HIBERNATE.
// - On-button active over 40 ms starts.
// - Wake GPIO active over 40 ms starts.
// - Power-on GPIO active over 40 ms starts.
// - Hardware strap picks one of four modes.
// - HIBERNATE supplies follow programmed enables.
module pwsc_top #(
   parameter int N_CONV   = pwsc_pkg::N_CONV,
   parameter int N_LDO    = pwsc_pkg::N_LDO,
   parameter int DEB_CYC  = pwsc_pkg::DEBOUNCE_CYC
) (
   input  wire logic                        i_clk,          // Slow always-on clock
   input  wire logic                        i_nrst,         // Power-on reset, active low
   input  wire logic                        i_ce,           // Clock enable
   input  wire logic [pwsc_pkg::ADDR_W-1:0] i_addr,         // Register address
   input  wire logic [pwsc_pkg::DATA_W-1:0] i_wdata,        // Register write data
   input  wire logic                        i_wr,           // Write strobe
   input  wire logic                        i_rd,           // Read strobe
   output logic      [pwsc_pkg::DATA_W-1:0] o_rdata,        // Read data, next cycle
   input  wire logic [1:0]                  i_mode_strap,   // Configuration mode pins
   input  wire logic                        i_on_button,    // On-button pin
   input  wire logic                        i_gpio_wake,    // Wake-input GPIO
   input  wire logic                        i_gpio_pwron,   // Power-on-request GPIO
   input  wire logic                        i_gpio_hib_lvl, // Hibernate-level GPIO
   input  wire logic                        i_gpio_hib_edge,// Hibernate-edge GPIO
   input  wire logic                        i_line_uvlo_ok, // Source above lockout
   input  wire logic                        i_line_shdn_ok, // Source above shutdown
   input  wire logic                        i_backup_por_ok,// Backup above POR
   input  wire logic                        i_shutdown_evt, // Shutdown event pulse
   input  wire logic                        i_wake_evt,     // Other wake-up event pulse
   input  wire logic                        i_fault,        // Fault condition level
   input  wire logic                        i_seq_done,     // Start-up sequence complete
   output logic                             o_seq_start,    // Run start-up sequence
   output pwsc_pkg::pwsc_supply_s           o_supply_en,    // Converter and LDO enables
   output logic                             o_backup_run,   // Backup supply running
   output logic                             o_osc_rtc_en,   // Oscillator and RTC enable
   output logic                             o_fast_chg_en,  // Fast charge permit
   output logic                             o_trickle_en,   // Trickle charge permit
   output logic [5:0]                       o_state         // One-hot operating state
);

   ////////////////////////////////////////////////////////////////////////////
   localparam int NPIN = 8;

   logic                       rst_meta;
   logic                       rst_n;
   logic [NPIN-1:0]            pin_raw;
   logic [NPIN-1:0]            pin_s1;
   logic [NPIN-1:0]            pin_s2;
   logic [NPIN-1:0]            pin_s3;
   logic [NPIN-1:0]            pin_q;
   logic [15:0]                lp_reg;
   logic [15:0]                lp_next;
   logic [15:0]                cfg_reg;
   logic [15:0]                cfg_next;
   logic [15:0]                hib_reg;
   logic [15:0]                hib_next;
   logic [15:0]                rdata_reg;
   logic [1:0]                 mode_reg;
   logic                       mode_cap_reg;
   logic                       hib_edge_reg;
   pwsc_pkg::pwsc_state_e      state_reg;
   pwsc_pkg::pwsc_state_e      state_next;

   // The reset is released through two flip-flops.
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pins and comparators cross in through three flops; a change is taken
   // once the second and third flop agree.
   assign pin_raw = {i_fault, i_backup_por_ok, i_line_shdn_ok, i_line_uvlo_ok,
                     i_gpio_hib_edge, i_gpio_hib_lvl, i_gpio_pwron, i_on_button};

   logic gpio_wake_q;
   logic gw_s1;
   logic gw_s2;
   logic gw_s3;

   genvar gp;
   generate
      for (gp = 0; gp < NPIN; gp++)
      begin : g_sync
         always_ff @(posedge i_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               pin_s1[gp] <= 1'b0;
               pin_s2[gp] <= 1'b0;
               pin_s3[gp] <= 1'b0;
               pin_q[gp]  <= 1'b0;
            end
            else if (i_ce)
            begin
               pin_s1[gp] <= pin_raw[gp];
               pin_s2[gp] <= pin_s1[gp];
               pin_s3[gp] <= pin_s2[gp];
               if (pin_s2[gp] == pin_s3[gp])
               begin
                  pin_q[gp] <= pin_s3[gp];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gw_s1       <= 1'b0;
         gw_s2       <= 1'b0;
         gw_s3       <= 1'b0;
         gpio_wake_q <= 1'b0;
      end
      else if (i_ce)
      begin
         gw_s1 <= i_gpio_wake;
         gw_s2 <= gw_s1;
         gw_s3 <= gw_s2;
         if (gw_s2 == gw_s3)
         begin
            gpio_wake_q <= gw_s3;
         end
      end
   end

   wire on_q       = pin_q[0];
   wire pwron_q    = pin_q[1];
   wire hib_lvl_q  = pin_q[2];
   wire hib_edge_q = pin_q[3];
   wire uvlo_ok    = pin_q[4];
   wire shdn_ok    = pin_q[5];
   wire bkup_ok    = pin_q[6];
   wire fault_q    = pin_q[7];

   ////////////////////////////////////////////////////////////////////////////
   // Start-up input debounce: 0 on-button, 1 wake GPIO, 2 power-on GPIO.
   logic [2:0]                      su_active;
   logic [2:0]                      su_evt;
   logic [2:0]                      su_done;
   logic [pwsc_pkg::DEB_W-1:0]      deb_cnt [3];

   assign su_active[0] = on_q        == cfg_reg[pwsc_pkg::BIT_ON_BUTTON_POLARITY];
   assign su_active[1] = gpio_wake_q == cfg_reg[pwsc_pkg::BIT_WAKE_POL];
   assign su_active[2] = pwron_q     == cfg_reg[pwsc_pkg::BIT_PWRON_POL];

   genvar gd;
   generate
      for (gd = 0; gd < 3; gd++)
      begin : g_deb
         assign su_evt[gd] = su_active[gd] && !su_done[gd]
                          && (deb_cnt[gd] == pwsc_pkg::DEB_W'(DEB_CYC - 1));
         always_ff @(posedge i_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               deb_cnt[gd] <= '0;
               su_done[gd] <= 1'b0;
            end
            else if (i_ce)
            begin
               if (!su_active[gd])
               begin
                  deb_cnt[gd] <= '0;
                  su_done[gd] <= 1'b0;
               end
               else if (su_evt[gd])
               begin
                  su_done[gd] <= 1'b1;
               end
               else if (!su_done[gd])
               begin
                  deb_cnt[gd] <= deb_cnt[gd] + 1'b1;
               end
            end
         end
      end
   endgenerate

   wire startup_evt = |su_evt;

   ////////////////////////////////////////////////////////////////////////////
   // Hibernate request sources.
   wire hib_lvl_act  = hib_lvl_q == cfg_reg[pwsc_pkg::BIT_HIB_POL];
   wire hib_edge_evt = hib_edge_q && !hib_edge_reg;
   wire lp_req       = lp_reg[pwsc_pkg::BIT_LP_REQ];
   wire develop      = mode_reg == pwsc_pkg::MODE_DEVELOP;
   wire seq_go       = cfg_reg[pwsc_pkg::BIT_SEQ_GO];
   wire seq_run      = (state_reg == pwsc_pkg::ST_PREACT) && (!develop || seq_go);

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         pwsc_pkg::ST_ZERO:
         begin
            if (uvlo_ok)
               state_next = pwsc_pkg::ST_OFF;
            else if (bkup_ok)
               state_next = pwsc_pkg::ST_BACKUP;
         end
         pwsc_pkg::ST_BACKUP:
         begin
            if (uvlo_ok)
               state_next = pwsc_pkg::ST_OFF;
         end
         pwsc_pkg::ST_OFF:
         begin
            if (!uvlo_ok)
               state_next = pwsc_pkg::ST_BACKUP;
            else if (startup_evt || i_wake_evt)
               state_next = pwsc_pkg::ST_PREACT;
         end
         pwsc_pkg::ST_PREACT:
         begin
            if (fault_q || !shdn_ok)
               state_next = pwsc_pkg::ST_OFF;
            else if (seq_run && i_seq_done)
               state_next = pwsc_pkg::ST_ACTIVE;
         end
         pwsc_pkg::ST_ACTIVE:
         begin
            if (i_shutdown_evt || !shdn_ok)
               state_next = pwsc_pkg::ST_OFF;
            else if (lp_req || hib_lvl_act || hib_edge_evt)
               state_next = pwsc_pkg::ST_HIB;
         end
         pwsc_pkg::ST_HIB:
         begin
            if (fault_q || i_shutdown_evt || !shdn_ok)
               state_next = pwsc_pkg::ST_OFF;
            else if ((!hib_lvl_act && !lp_req) || hib_edge_evt
                     || i_wake_evt || startup_evt)
               state_next = pwsc_pkg::ST_ACTIVE;
         end
         default:
         begin
            state_next = pwsc_pkg::ST_ZERO;
         end
      endcase
      if (!uvlo_ok && !bkup_ok)
         state_next = pwsc_pkg::ST_ZERO;
   end

   wire enter_off  = (state_next == pwsc_pkg::ST_OFF) && (state_reg != pwsc_pkg::ST_OFF);
   wire regs_clear = enter_off || (state_next == pwsc_pkg::ST_ZERO);

   ////////////////////////////////////////////////////////////////////////////
   // Register writes; entering OFF or ZERO restores the defaults.
   wire wr_lp  = i_wr && (i_addr == pwsc_pkg::OFS_LOW_POWER);
   wire wr_cfg = i_wr && (i_addr == pwsc_pkg::OFS_CONFIG);
   wire wr_hib = i_wr && (i_addr == pwsc_pkg::OFS_HIB_SUPPLY);

   assign lp_next  = regs_clear ? pwsc_pkg::RST_LOW_POWER
                   : wr_lp ? i_wdata : lp_reg;
   assign hib_next = regs_clear ? pwsc_pkg::RST_HIB_SUPPLY
                   : wr_hib ? i_wdata : hib_reg;
   assign cfg_next = regs_clear ? pwsc_pkg::RST_CONFIG
                   : wr_cfg ? i_wdata
                   : (state_reg != pwsc_pkg::ST_PREACT) ? (cfg_reg & ~16'h0010)
                   : cfg_reg;

   wire [15:0] rd_mux =
        (i_addr == pwsc_pkg::OFS_LOW_POWER)  ? lp_reg
      : (i_addr == pwsc_pkg::OFS_CONFIG)     ? cfg_reg
      : (i_addr == pwsc_pkg::OFS_HIB_SUPPLY) ? hib_reg
      : (i_addr == pwsc_pkg::OFS_STATUS)     ? {6'h00, mode_reg, 2'h0, state_reg}
      : 16'h0000;

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lp_reg    <= pwsc_pkg::RST_LOW_POWER;
         cfg_reg   <= pwsc_pkg::RST_CONFIG;
         hib_reg   <= pwsc_pkg::RST_HIB_SUPPLY;
         rdata_reg <= 16'h0000;
      end
      else if (i_ce)
      begin
         lp_reg    <= lp_next;
         cfg_reg   <= cfg_next;
         hib_reg   <= hib_next;
         rdata_reg <= i_rd ? rd_mux : 16'h0000;
      end
   end

   // The mode strap is caught once, in the first enabled cycle after release.
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_reg     <= 2'h0;
         mode_cap_reg <= 1'b0;
      end
      else if (i_ce && !mode_cap_reg)
      begin
         mode_reg     <= i_mode_strap;
         mode_cap_reg <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg    <= pwsc_pkg::ST_ZERO;
         hib_edge_reg <= 1'b0;
      end
      else if (i_ce && mode_cap_reg)
      begin
         state_reg    <= state_next;
         hib_edge_reg <= hib_edge_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Supply and charger outputs, all registered.
   pwsc_pkg::pwsc_supply_s sup_next;

   always_comb
   begin
      sup_next = '0;
      case (state_reg)
         pwsc_pkg::ST_PREACT,
         pwsc_pkg::ST_ACTIVE:
         begin
            sup_next = '1;
         end
         pwsc_pkg::ST_HIB:
         begin
            sup_next = hib_reg[N_CONV+N_LDO-1:0];
         end
         pwsc_pkg::ST_OFF:
         begin
            sup_next.ldo[0] = cfg_reg[pwsc_pkg::BIT_FIRST_LINEAR_REGULATOR_KEEP];
         end
         default:
         begin
            sup_next = '0;
         end
      endcase
   end

   wire on_state   = state_reg inside {pwsc_pkg::ST_OFF, pwsc_pkg::ST_ACTIVE,
                                       pwsc_pkg::ST_HIB, pwsc_pkg::ST_PREACT};

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_supply_en   <= '0;
         o_backup_run  <= 1'b0;
         o_osc_rtc_en  <= 1'b0;
         o_fast_chg_en <= 1'b0;
         o_trickle_en  <= 1'b0;
         o_seq_start   <= 1'b0;
         o_state       <= 6'h01;
      end
      else if (i_ce)
      begin
         o_supply_en   <= sup_next;
         o_backup_run  <= state_reg != pwsc_pkg::ST_ZERO;
         o_osc_rtc_en  <= state_reg != pwsc_pkg::ST_ZERO;
         o_fast_chg_en <= state_reg == pwsc_pkg::ST_ACTIVE;
         o_trickle_en  <= on_state;
         o_seq_start   <= seq_run;
         o_state       <= state_reg;
      end
   end

   assign o_rdata = rdata_reg;

endmodule : pwsc_top

/* File: verif/pwsc_seq_model.sv */
`timescale 1ns/10ps
module pwsc_seq_model (
   input  wire logic       i_clk,       // Device clock
   input  wire logic       i_nrst,      // Reset, active low
   input  wire logic [3:0] i_delay,     // Cycles from request to completion
   input  wire logic       i_seq_start, // Sequence request from the device
   output logic            o_seq_done   // Sequence complete
);
   logic [3:0] cnt_reg;

   // Completion is held until the device withdraws its request, then dropped.
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cnt_reg    <= 4'h0;
         o_seq_done <= 1'b0;
      end
      else if (!i_seq_start)
      begin
         cnt_reg    <= 4'h0;
         o_seq_done <= 1'b0;
      end
      else if (cnt_reg == i_delay)
         o_seq_done <= 1'b1;
      else
         cnt_reg <= cnt_reg + 4'h1;
   end
endmodule : pwsc_seq_model

/* File: verif/pwsc_top_sva.sv */
`timescale 1ns/10ps
module pwsc_top_sva #(
   parameter int DEB_CYC = pwsc_pkg::DEBOUNCE_CYC
) (
   input wire logic                  i_clk,          // Clock
   input wire logic                  i_nrst,         // Reset, active low
   input wire logic [7:0]            i_addr,         // Register address
   input wire logic [15:0]           i_wdata,        // Write data
   input wire logic                  i_wr,           // Write strobe
   input wire logic                  i_rd,           // Read strobe
   input wire logic [15:0]           o_rdata,        // Read data
   input wire logic                  i_fault,        // Fault level
   input wire logic                  i_line_shdn_ok, // Source above shutdown
   input wire logic                  i_seq_done,     // Sequence complete
   input wire pwsc_pkg::pwsc_supply_s o_supply_en,   // Supply enables
   input wire logic                  o_backup_run,   // Backup supply running
   input wire logic                  o_osc_rtc_en,   // Oscillator enable
   input wire logic                  o_fast_chg_en,  // Fast charge permit
   input wire logic                  o_trickle_en,   // Trickle charge permit
   input wire logic [5:0]            o_state         // Operating state
);
   localparam logic [5:0] ZR = 6'h01, BK = 6'h02, OF = 6'h04, PA = 6'h08, AC = 6'h10, HB = 6'h20;
   logic [9:0] hib_sup_reg;
   logic [5:0] st_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Shadow of the hibernate supply register, restored on entry to OFF.
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         hib_sup_reg <= 10'h000;
         st_q        <= ZR;
      end
      else
      begin
         st_q <= o_state;
         if (o_state == OF && st_q != OF)
            hib_sup_reg <= 10'h000;
         else if (i_wr && i_addr == pwsc_pkg::OFS_HIB_SUPPLY)
            hib_sup_reg <= i_wdata[9:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   a_active_via_pre: assert property (o_state == AC && $past(o_state) != AC
      |-> $past(o_state) == PA || $past(o_state) == HB) else $error("active from wrong state");
   a_active_cause: assert property (o_state == AC && $past(o_state) == PA
      |-> $past(i_seq_done)) else $error("active without finished sequence");
   a_hib_from_active: assert property (o_state == HB && $past(o_state) != HB
      |-> $past(o_state) == AC) else $error("hibernate from wrong state");
   a_hib_charge: assert property (o_state == HB |-> !o_fast_chg_en && o_trickle_en)
      else $error("charge permits wrong in hibernate");
   a_hib_supply: assert property (o_state == HB && $past(o_state) == HB
      && $past(o_state, 2) == HB && hib_sup_reg == $past(hib_sup_reg, 3)
      |-> o_supply_en == hib_sup_reg) else $error("hibernate supplies differ");
   a_fault_hib_off: assert property ((i_fault && o_state == HB) [*6] |=> o_state == OF)
      else $error("fault left device in hibernate");
   a_shdn_off: assert property ((!i_line_shdn_ok && o_state == AC) [*6] |=> o_state == OF)
      else $error("low source left device active");
   a_off_supplies: assert property (o_state == OF |-> o_supply_en.conv == '0
      && o_supply_en.ldo[3:1] == 3'h0 && o_backup_run) else $error("supplies on in off");
   a_backup_only: assert property (o_state == BK |-> o_supply_en == '0 && o_osc_rtc_en
      && !o_fast_chg_en && !o_trickle_en) else $error("backup outputs wrong");
   a_zero_dead: assert property (o_state == ZR |-> o_supply_en == '0 && !o_osc_rtc_en
      && !o_backup_run) else $error("zero outputs not off");
   a_lp_readback: assert property (i_wr && i_addr == 8'h05 ##2 i_rd && i_addr == 8'h05
      |=> o_rdata == $past(i_wdata, 3)) else $error("low power register readback wrong");

   c_active: cover property (o_state == AC);
   c_hib: cover property (o_state == HB);
   c_backup: cover property (o_state == BK);
endmodule : pwsc_top_sva

/* File: verif/power_state_controller_test.sv */
`timescale 1ns/10ps
module power_state_controller_test;
   localparam int DEB = 8;
   localparam logic [5:0] ZR = 6'h01, BK = 6'h02, OF = 6'h04, PA = 6'h08, AC = 6'h10, HB = 6'h20;
   typedef struct packed {logic wr; logic [7:0] addr; logic [15:0] data;} pwsc_row_s;
   localparam pwsc_row_s ROWS [10] = '{
      '{1'b0, 8'h05, 16'h0000}, '{1'b0, 8'h06, 16'h000f}, '{1'b0, 8'h07, 16'h0000},
      '{1'b0, 8'h08, 16'h0104}, '{1'b1, 8'h30, 16'hffff}, '{1'b0, 8'h30, 16'h0000},
      '{1'b1, 8'h05, 16'h0123}, '{1'b0, 8'h05, 16'h0123}, '{1'b1, 8'h07, 16'h03a5},
      '{1'b0, 8'h07, 16'h03a5}};
   logic clk = 1'b0, nrst = 1'b0, wr_s = 1'b0, rd_s = 1'b0, hib_lvl = 1'b0, fault = 1'b0;
   logic uvlo = 1'b1, shdn = 1'b1, bkp = 1'b1, seq_done, seq_start, backup_run, osc, fast, trickle;
   logic ce = 1'b1;
   logic [1:0] strap = 2'h1;
   logic [2:0] start_pins = 3'h0, evts = 3'h0;
   logic [3:0] dly = 4'h0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000, rdata, rdv;
   logic [5:0] state;
   pwsc_pkg::pwsc_supply_s sup;
   int err_count = 0, comparisons = 0;

   always #25 clk = ~clk;

   pwsc_top #(.DEB_CYC(DEB)) DUT (.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_mode_strap(strap),
      .i_on_button(start_pins[0]), .i_gpio_wake(start_pins[1]), .i_gpio_pwron(start_pins[2]),
      .i_gpio_hib_lvl(hib_lvl), .i_gpio_hib_edge(evts[2]), .i_line_uvlo_ok(uvlo),
      .i_line_shdn_ok(shdn), .i_backup_por_ok(bkp), .i_shutdown_evt(evts[0]),
      .i_wake_evt(evts[1]), .i_fault(fault), .i_seq_done(seq_done), .o_seq_start(seq_start),
      .o_supply_en(sup), .o_backup_run(backup_run), .o_osc_rtc_en(osc),
      .o_fast_chg_en(fast), .o_trickle_en(trickle), .o_state(state));
   pwsc_seq_model u_seq (.i_clk(clk), .i_nrst(nrst), .i_delay(dly), .i_seq_start(seq_start),
      .o_seq_done(seq_done));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wait_st(input logic [5:0] exp, input int lim);
      int n;
      n = 0;
      while (state !== exp && n < lim)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("state", 16'(exp), 16'(state));
   endtask : wait_st

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask : rd

   task automatic press(input int pin, input int len);
      @(posedge clk);
      start_pins[pin] <= 1'b1;
      repeat (len) @(posedge clk);
      start_pins[pin] <= 1'b0;
   endtask : press

   task automatic pulse(input int idx, input int len);
      @(posedge clk);
      evts[idx] <= 1'b1;
      repeat (len) @(posedge clk);
      evts[idx] <= 1'b0;
   endtask : pulse

   task automatic do_reset(input logic [1:0] s);
      @(posedge clk);
      nrst  <= 1'b0;
      strap <= s;
      repeat (6) @(posedge clk);
      chk("reset state", 16'h0001, 16'(state));
      nrst <= 1'b1;
      wait_st(OF, 40);
   endtask : do_reset

   task automatic give_verdict;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      do_reset(2'h1);
      chk("off supplies", 16'h0000, 16'(sup));
      chk("off flags", 16'h0003, {13'h0, fast, trickle, osc});
      $display("test off done");
      foreach (ROWS[i])
      begin
         if (ROWS[i].wr)
            wr(ROWS[i].addr, ROWS[i].data);
         else
         begin
            rd(ROWS[i].addr, rdv);
            chk("register", ROWS[i].data, rdv);
         end
      end
      $display("test registers done");
      press(0, 5);
      repeat (6) @(posedge clk);
      press(0, 5);
      repeat (30) @(posedge clk);
      wait_st(OF, 0);
      $display("test early release done");
      for (int k = 0; k < 3; k++)
      begin
         @(posedge clk);
         dly <= 4'(k * 6);
         press(k, 40);
         wait_st(AC, 20);
         chk("active fast charge", 16'h0001, {15'h0, fast});
         if (k == 0)
         begin
            wr(8'h05, 16'h8000);
            wait_st(HB, 10);
            chk("hib charge", 16'h0001, {14'h0, fast, trickle});
            chk("hib supplies", 16'h03a5, 16'(sup));
            wr(8'h05, 16'h0000);
            wait_st(AC, 10);
            pulse(0, 1);
            wait_st(OF, 10);
         end
         else if (k == 1)
         begin
            @(posedge clk);
            hib_lvl <= 1'b1;
            wait_st(HB, 12);
            pulse(1, 1);
            wait_st(AC, 10);
            wait_st(HB, 12);
            wr(8'h05, 16'h8123);
            @(posedge clk);
            fault <= 1'b1;
            wait_st(OF, 12);
            @(posedge clk);
            fault   <= 1'b0;
            hib_lvl <= 1'b0;
            rd(8'h05, rdv);
            chk("restored low power", 16'h0000, rdv);
         end
         else
         begin
            pulse(2, 4);
            wait_st(HB, 12);
            wait_st(AC, 8);
            @(posedge clk);
            shdn <= 1'b0;
            wait_st(OF, 12);
            @(posedge clk);
            shdn <= 1'b1;
         end
         $display("test start pin %0d done", k);
      end
      @(posedge clk);
      ce   <= 1'b0;
      uvlo <= 1'b0;
      repeat (12) @(posedge clk);
      ce <= 1'b1;
      #1 chk("frozen state", 16'(OF), 16'(state));
      wait_st(BK, 12);
      chk("backup supplies", 16'h0000, 16'(sup));
      chk("backup flags", 16'h0004, {13'h0, osc, fast, trickle});
      @(posedge clk);
      uvlo <= 1'b1;
      wait_st(OF, 12);
      @(posedge clk);
      uvlo <= 1'b0;
      bkp  <= 1'b0;
      wait_st(ZR, 12);
      chk("zero oscillator", 16'h0000, {14'h0, osc, backup_run});
      @(posedge clk);
      uvlo <= 1'b1;
      bkp  <= 1'b1;
      wait_st(OF, 40);
      $display("test supplies done");
      do_reset(2'h0);
      press(0, 20);
      wait_st(PA, 10);
      repeat (20) @(posedge clk);
      #1 chk("development hold", 16'h0008, {9'h0, seq_start, state});
      wr(8'h06, 16'h001f);
      wait_st(AC, 30);
      $display("test development mode done");
      give_verdict;
   end

   initial
   begin
      #(20_000 * 50);
      err_count++;
      $display("watchdog expired");
      give_verdict;
   end
endmodule : power_state_controller_test

bind pwsc_top pwsc_top_sva #(.DEB_CYC(DEB_CYC)) u_sva (.i_clk(i_clk), .i_nrst(i_nrst),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_fault(i_fault), .i_line_shdn_ok(i_line_shdn_ok), .i_seq_done(i_seq_done),
   .o_supply_en(o_supply_en), .o_backup_run(o_backup_run), .o_osc_rtc_en(o_osc_rtc_en),
   .o_fast_chg_en(o_fast_chg_en), .o_trickle_en(o_trickle_en), .o_state(o_state));
